// ===== design/tmr_pair.sv
/*
  timer 0 / timer 1 counter pair with run, gate, overflow and external
  interrupt flags, reached over the special-function register bus.
  assumes a single-cycle register bus on mclk_i, interrupt vector acks as
  one-cycle pulses from the core, and polarity bits from same-clock logic.
*/
// Overview of operation
// (R01) 13-bit mode: high byte holds upper eight bits, low byte bits 4..0.
// (R02) 13-bit rollover from all ones sets overflow flag, requests interrupt.
// (R03) counter select 1: count falling edges of the timer's count pin.
// (R04) counter select 0: count the internal clock chosen by clock select.
// (R05) count only when run set and gate off or gate input active.
// (R06) setting run never clears count; software preloads the start value.
// (R07) timer 1 mirrors timer 0 with its own bits and second ext input.
// (R08) 16-bit mode counts all sixteen bits, enabled like 13-bit mode.
// (R09) auto-reload: low byte counts, overflow sets flag, reloads from high.
// (R10) split mode: timer 0 low byte is an 8-bit counter with own bits.
// (R11) split mode: high byte times, run by timer 1 run, sets timer 1 flag.
// (R12) during split, timer 1 counts internally only, never sets its flag.
// (R13) timer 1 stops in mode 3, runs in modes 0 to 2 during split.
// (R14) overflow flags set by hardware, cleared by software or vectoring.
// (R15) control register at 0x88 holds flags, runs, ext-int bits; resets 0.
// (R16) ext flag set on selected edge or level; edge mode clears on vector.
// (R17) type bit 0 selects level, 1 edge; polarity from a separate bit.
// (R18) mode field: 00 13-bit, 01 16-bit, 10 reload, 11 split/inactive.
// (R19) prescaler: divide by 12, 4, 48, or external clock divided by 8.
// (R20) clock select 0 picks prescaler, 1 the system clock.
// (R21) count and gate pins synchronised before edge detection.
`timescale 1ns/1ps
module tmr_pair (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic tmr_zero_count_pin_i,
  input wire logic tmr_one_count_pin_i,
  input wire logic ext_irq_zero_input_i,
  input wire logic ext_irq_one_input_i,
  input wire logic ext_clk_i,
  input wire logic ext_irq_zero_polarity_i,
  input wire logic ext_irq_one_polarity_i,
  input wire logic tmr_zero_vector_ack_i,
  input wire logic tmr_one_vector_ack_i,
  input wire logic ext_irq_zero_vector_ack_i,
  input wire logic ext_irq_one_vector_ack_i,
  output logic tmr_zero_overflow_flag_o,
  output logic tmr_one_overflow_flag_o,
  output logic ext_irq_zero_flag_o,
  output logic ext_irq_one_flag_o,
  output logic tmr_one_overflow_pulse_o
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------------
  // step of one timer: {overflow, high byte, low byte}
  // ----------------------------------------------------------------------
  function automatic logic [16:0] count_step(input tmr_mode_t mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      // upper low-byte bits are left as they are [R01]
      MODE_13BIT: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // [R02]
      MODE_16BIT: r = s16; // [R08]
      MODE_RELOAD: begin
        if (lo == BYTE_ONES) begin
          r = {1'b1, hi, hi}; // [R09]
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
      default: r = {(lo == BYTE_ONES), hi, lo + 8'h01}; // [R10]
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and prescaler
  // ----------------------------------------------------------------------
  logic [4:0] pins_q;
  logic t0_pin;
  logic t1_pin;
  logic ext_irq_zero_input_pin;
  logic ext_irq_one_input_pin;
  logic [3:0] prev;
  logic [3:0] next_prev;
  prescale_if ps ();

  pin_sync #(.WIDTH(5)) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i({ext_clk_i, ext_irq_one_input_i, ext_irq_zero_input_i,
          tmr_one_count_pin_i, tmr_zero_count_pin_i}),
    .q_o(pins_q)
  ); // [R21]

  tmr_prescaler #(.CNT_W(6)) u_pre (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ps(ps.gen)
  );

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] timer_run_flag_control;
  logic [7:0] timer_mode_select_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] tl0;
  logic [7:0] th0;
  logic [7:0] tl1;
  logic [7:0] th1;
  logic [7:0] next_timer_run_flag_control;
  logic [7:0] next_timer_mode_select_reg;
  logic [7:0] next_clock_control_reg;
  logic [7:0] next_tl0;
  logic [7:0] next_th0;
  logic [7:0] next_tl1;
  logic [7:0] next_th1;
  logic [7:0] next_rdata;
  logic next_pulse;

  // ----------------------------------------------------------------------
  // count enables
  // ----------------------------------------------------------------------
  tmr_mode_t t0_mode;
  tmr_mode_t t1_mode;
  logic split;
  logic act0;
  logic act1;
  logic t0_fall;
  logic t1_fall;
  logic t0_time_tick;
  logic t1_time_tick;
  logic t0_en;
  logic th0_en;
  logic t1_en;
  logic [16:0] step0;
  logic [16:0] step1;
  logic ovf0;
  logic th0_ovf;
  logic ovf1;
  logic edge0;
  logic edge1;
  logic wr_timer_run_flag_control;

  always_comb begin
    t0_pin = pins_q[0];
    t1_pin = pins_q[1];
    ext_irq_zero_input_pin = pins_q[2];
    ext_irq_one_input_pin = pins_q[3];
    ps.ext_clk = pins_q[4];
    ps.scale = clock_control_reg[SCALE_LSB +: 2]; // [R19]
    next_prev = {ext_irq_one_input_pin, ext_irq_zero_input_pin, t1_pin, t0_pin};
    t0_fall = prev[0] & ~t0_pin; // [R03] [R21]
    t1_fall = prev[1] & ~t1_pin; // [R03] [R07]
    act0 = ext_irq_zero_polarity_i ? ext_irq_zero_input_pin : ~ext_irq_zero_input_pin; // [R17]
    act1 = ext_irq_one_polarity_i ? ext_irq_one_input_pin : ~ext_irq_one_input_pin; // [R17]
    edge0 = act0 & ~(ext_irq_zero_polarity_i ? prev[2] : ~prev[2]);
    edge1 = act1 & ~(ext_irq_one_polarity_i ? prev[3] : ~prev[3]);
    t0_mode = tmr_mode_t'(timer_mode_select_reg[T0_MODE_LSB +: 2]); // [R18]
    t1_mode = tmr_mode_t'(timer_mode_select_reg[T1_MODE_LSB +: 2]); // [R18]
    split = (t0_mode == MODE_SPLIT);
    t0_time_tick = clock_control_reg[T0_CLK_SEL] | ps.tick; // [R04] [R20]
    t1_time_tick = clock_control_reg[T1_CLK_SEL] | ps.tick; // [R04] [R20]
    // gate lets an external level bracket the count for width capture
    t0_en = timer_run_flag_control[TR0] & (~timer_mode_select_reg[T0_GATE] | act0)
            & (timer_mode_select_reg[T0_CT] ? t0_fall : t0_time_tick); // [R05] [R03]
    th0_en = split & timer_run_flag_control[TR1] & t0_time_tick; // [R11]
    if (t1_mode == MODE_SPLIT) begin
      t1_en = 1'b0; // [R13]
    end else if (split) begin
      t1_en = t1_time_tick; // [R12] [R13]
    end else begin
      t1_en = timer_run_flag_control[TR1] & (~timer_mode_select_reg[T1_GATE] | act1)
              & (timer_mode_select_reg[T1_CT] ? t1_fall : t1_time_tick); // [R05] [R07]
    end
    step0 = count_step(t0_mode, th0, tl0);
    step1 = count_step(t1_mode, th1, tl1);
    ovf0 = t0_en & step0[16]; // [R02]
    th0_ovf = th0_en & (th0 == BYTE_ONES); // [R11]
    ovf1 = t1_en & step1[16];
  end

  // ----------------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------------
  always_comb begin
    wr_timer_run_flag_control = sfr_wr_i & (sfr_addr_i == ADDR_TIMER_RUN_FLAG_CONTROL);
    next_timer_mode_select_reg = (sfr_wr_i && sfr_addr_i == ADDR_TIMER_MODE_SELECT_REG) ? sfr_wdata_i : timer_mode_select_reg;
    next_clock_control_reg = (sfr_wr_i && sfr_addr_i == ADDR_CLOCK_CONTROL_REG) ?
                 (sfr_wdata_i & CLOCK_CONTROL_REG_MASK) : clock_control_reg;
    // run bit never touches the count, so counting resumes from the
    // preloaded value [R06]
    next_tl0 = t0_en ? step0[7:0] : tl0;
    if (split) begin
      next_th0 = th0_en ? th0 + 8'h01 : th0; // [R11]
    end else begin
      next_th0 = t0_en ? step0[15:8] : th0;
    end
    next_tl1 = t1_en ? step1[7:0] : tl1;
    next_th1 = t1_en ? step1[15:8] : th1;
    // a software write to a count byte wins over the count that cycle
    if (sfr_wr_i && sfr_addr_i == ADDR_TL0) begin
      next_tl0 = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == ADDR_TH0) begin
      next_th0 = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == ADDR_TL1) begin
      next_tl1 = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == ADDR_TH1) begin
      next_th1 = sfr_wdata_i;
    end
    next_timer_run_flag_control = wr_timer_run_flag_control ? sfr_wdata_i : timer_run_flag_control; // [R15]
    // clears first, hardware sets after, so a set in the clear cycle wins
    if (tmr_zero_vector_ack_i) begin
      next_timer_run_flag_control[TF0] = 1'b0; // [R14]
    end
    if (tmr_one_vector_ack_i) begin
      next_timer_run_flag_control[TF1] = 1'b0; // [R14]
    end
    if (ext_irq_zero_vector_ack_i && next_timer_run_flag_control[IT0]) begin
      next_timer_run_flag_control[IE0] = 1'b0; // [R16]
    end
    if (ext_irq_one_vector_ack_i && next_timer_run_flag_control[IT1]) begin
      next_timer_run_flag_control[IE1] = 1'b0; // [R16]
    end
    next_timer_run_flag_control[TF0] = next_timer_run_flag_control[TF0] | ovf0; // [R14] [R02]
    next_timer_run_flag_control[TF1] = next_timer_run_flag_control[TF1] | th0_ovf | (ovf1 & ~split); // [R12]
    next_timer_run_flag_control[IE0] = next_timer_run_flag_control[IE0]
                     | (next_timer_run_flag_control[IT0] ? edge0 : act0); // [R16] [R17]
    next_timer_run_flag_control[IE1] = next_timer_run_flag_control[IE1]
                     | (next_timer_run_flag_control[IT1] ? edge1 : act1); // [R16] [R17]
    // overflow still feeds baud and peripheral users during split [R12]
    next_pulse = ovf1;
    next_rdata = sfr_rdata_o;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        ADDR_TIMER_RUN_FLAG_CONTROL: next_rdata = timer_run_flag_control;
        ADDR_TIMER_MODE_SELECT_REG: next_rdata = timer_mode_select_reg;
        ADDR_TL0: next_rdata = tl0; // [R01]
        ADDR_TL1: next_rdata = tl1;
        ADDR_TH0: next_rdata = th0;
        ADDR_TH1: next_rdata = th1;
        ADDR_CLOCK_CONTROL_REG: next_rdata = clock_control_reg;
        default: next_rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_run_flag_control <= REG_RESET; // [R15]
      timer_mode_select_reg <= REG_RESET;
      clock_control_reg <= REG_RESET;
      tl0 <= REG_RESET;
      th0 <= REG_RESET;
      tl1 <= REG_RESET;
      th1 <= REG_RESET;
      sfr_rdata_o <= REG_RESET;
      tmr_one_overflow_pulse_o <= 1'b0;
      prev <= '0;
    end else begin
      timer_run_flag_control <= next_timer_run_flag_control;
      timer_mode_select_reg <= next_timer_mode_select_reg;
      clock_control_reg <= next_clock_control_reg;
      tl0 <= next_tl0;
      th0 <= next_th0;
      tl1 <= next_tl1;
      th1 <= next_th1;
      sfr_rdata_o <= next_rdata;
      tmr_one_overflow_pulse_o <= next_pulse;
      prev <= next_prev;
    end
  end

  always_comb begin
    tmr_zero_overflow_flag_o = timer_run_flag_control[TF0];
    tmr_one_overflow_flag_o = timer_run_flag_control[TF1];
    ext_irq_zero_flag_o = timer_run_flag_control[IE0];
    ext_irq_one_flag_o = timer_run_flag_control[IE1];
  end
endmodule

// ===== design/tmr_pkg.sv
/*
  shared constants for the timer pair: register addresses, field positions,
  reset values, mode and prescale encodings, divide ratios.
  assumes nothing of its surroundings; imported by the timer pair and its prescaler.
*/
package tmr_pkg;

  // ----------------------------------------------------------------------
  // register addresses on the special-function bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_RUN_FLAG_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT_REG = 8'h89;
  localparam logic [7:0] ADDR_TL0 = 8'h8A;
  localparam logic [7:0] ADDR_TL1 = 8'h8B;
  localparam logic [7:0] ADDR_TH0 = 8'h8C;
  localparam logic [7:0] ADDR_TH1 = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_REG = 8'h8E;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_REG_MASK = 8'h0F;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [4:0] LOW5_ONES = 5'h1F;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int TF1 = 7;
  localparam int TR1 = 6;
  localparam int TF0 = 5;
  localparam int TR0 = 4;
  localparam int IE1 = 3;
  localparam int IT1 = 2;
  localparam int IE0 = 1;
  localparam int IT0 = 0;

  localparam int T0_MODE_LSB = 0;
  localparam int T0_CT = 2;
  localparam int T0_GATE = 3;
  localparam int T1_MODE_LSB = 4;
  localparam int T1_CT = 6;
  localparam int T1_GATE = 7;

  localparam int SCALE_LSB = 0;
  localparam int T0_CLK_SEL = 2;
  localparam int T1_CLK_SEL = 3;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } tmr_mode_t;

  typedef enum logic [1:0] {
    SCALE_DIV12 = 2'h0,
    SCALE_DIV4 = 2'h1,
    SCALE_DIV48 = 2'h2,
    SCALE_EXT8 = 2'h3
  } scale_t;

  localparam int DIV_12 = 12;
  localparam int DIV_4 = 4;
  localparam int DIV_48 = 48;
  localparam int DIV_EXT = 8;

endpackage

// ===== design/prescale_if.sv
/*
  carrier between the timer core and its prescaler: scale choice, the
  synchronised external clock level and the returned count tick.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface prescale_if;
  logic [1:0] scale;
  logic ext_clk;
  logic tick;

  modport ctrl (output scale, output ext_clk, input tick);
  modport gen (input scale, input ext_clk, output tick);
endinterface

// ===== design/pin_sync.sv
/*
  two-flop synchroniser for a group of asynchronous pins.
  assumes the pins are slow against the system clock.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync width must be positive");
  end

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

// ===== design/tmr_prescaler.sv
/*
  shared timer prescaler: one-cycle tick every 12, 4 or 48 system clocks,
  or every 8th rising edge of the external clock.
  assumes the external clock level arrives already synchronised.
*/
`timescale 1ns/1ps
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int CNT_W = 6
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  prescale_if.gen ps
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;
  logic ext_prev;
  logic step;

  if ((2 ** CNT_W) < DIV_48) begin : g_chk
    $error("prescaler counter too narrow");
  end

  always_comb begin
    case (scale_t'(ps.scale))
      SCALE_DIV12: limit = CNT_W'(DIV_12 - 1);
      SCALE_DIV4: limit = CNT_W'(DIV_4 - 1);
      SCALE_DIV48: limit = CNT_W'(DIV_48 - 1);
      default: limit = CNT_W'(DIV_EXT - 1);
    endcase
    // external mode advances only on rising edges of the slow clock [R19]
    step = (scale_t'(ps.scale) == SCALE_EXT8) ? (ps.ext_clk & ~ext_prev)
                                             : 1'b1;
    // >= keeps a shrinking ratio from running the counter past its limit
    ps.tick = step & (cnt >= limit); // [R19]
    next_cnt = cnt;
    if (step) begin
      next_cnt = (cnt >= limit) ? '0 : cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
      ext_prev <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ext_prev <= ps.ext_clk;
    end
  end
endmodule

// ===== test/pin_model.sv
/*
  far side of the timer pair: the two external count pins.
  assumes the bench calls pulse() from its main sequence.
*/
`timescale 1ns/1ps
module pin_model (
  input wire logic mclk_i,
  output logic pin0_o,
  output logic pin1_o
);
  initial begin
    pin0_o = 1'b0;
    pin1_o = 1'b0;
  end
  // 2 cycles high, 2 low: shorter pulses may slip past the synchroniser
  task automatic pulse(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk_i);
      pin0_o <= 1'b1;
      pin1_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      pin0_o <= 1'b0;
      pin1_o <= 1'b0;
      @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// ===== test/tmr_pair_properties.sv
/*
  concurrent checks on the timer pair's register bus and flag outputs.
  assumes it is bound to tmr_pair and sees only its ports.
*/
`timescale 1ns/1ps
module tmr_pair_checker
  import tmr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic tmr_zero_vector_ack_i,
  input wire logic tmr_one_vector_ack_i,
  input wire logic ext_irq_zero_vector_ack_i,
  input wire logic ext_irq_one_vector_ack_i,
  input wire logic tmr_zero_overflow_flag_o,
  input wire logic tmr_one_overflow_flag_o,
  input wire logic ext_irq_zero_flag_o,
  input wire logic ext_irq_one_flag_o
);
  logic [3:0] flags;
  logic [3:0] wf;
  logic timer_run_flag_control_wr;
  logic acks;
  assign flags = {tmr_one_overflow_flag_o, tmr_zero_overflow_flag_o,
    ext_irq_one_flag_o, ext_irq_zero_flag_o};
  assign wf = {sfr_wdata_i[TF1], sfr_wdata_i[TF0], sfr_wdata_i[IE1],
    sfr_wdata_i[IE0]};
  assign timer_run_flag_control_wr = sfr_wr_i && sfr_addr_i == ADDR_TIMER_RUN_FLAG_CONTROL;
  // write against vector ack in one cycle is left open, so skip it
  assign acks = tmr_zero_vector_ack_i | tmr_one_vector_ack_i |
    ext_irq_zero_vector_ack_i | ext_irq_one_vector_ack_i;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_rd_unmapped: assert property (
    sfr_rd_i && (sfr_addr_i < ADDR_TIMER_RUN_FLAG_CONTROL || sfr_addr_i > ADDR_CLOCK_CONTROL_REG)
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
  a_timer_run_flag_control_rd_flags: assert property (
    sfr_rd_i && sfr_addr_i == ADDR_TIMER_RUN_FLAG_CONTROL |=> {sfr_rdata_o[7],
    sfr_rdata_o[5], sfr_rdata_o[3], sfr_rdata_o[1]} == $past(flags))
    else $error("control read differs from flags");
  a_clock_control_reg_upper_zero: assert property (
    sfr_rd_i && sfr_addr_i == ADDR_CLOCK_CONTROL_REG |=> sfr_rdata_o[7:4] == 4'h0)
    else $error("clock control upper bits not zero");
  a_timer_run_flag_control_wr_set: assert property (
    timer_run_flag_control_wr && !acks |=> (flags & $past(wf)) == $past(wf))
    else $error("written flag did not set");
  a_tf0_clear_cause: assert property (
    $fell(tmr_zero_overflow_flag_o) |-> $past(tmr_zero_vector_ack_i) ||
    $past(timer_run_flag_control_wr && !sfr_wdata_i[TF0])) else $error("timer0 flag lost");
  a_tf1_clear_cause: assert property (
    $fell(tmr_one_overflow_flag_o) |-> $past(tmr_one_vector_ack_i) ||
    $past(timer_run_flag_control_wr && !sfr_wdata_i[TF1])) else $error("timer1 flag lost");
  a_ie0_clear_cause: assert property (
    $fell(ext_irq_zero_flag_o) |-> $past(ext_irq_zero_vector_ack_i) ||
    $past(timer_run_flag_control_wr && !sfr_wdata_i[IE0])) else $error("ext0 flag lost");
  a_ie1_clear_cause: assert property (
    $fell(ext_irq_one_flag_o) |-> $past(ext_irq_one_vector_ack_i) ||
    $past(timer_run_flag_control_wr && !sfr_wdata_i[IE1])) else $error("ext1 flag lost");
endmodule

bind tmr_pair tmr_pair_checker i_tmr_pair_checker (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .tmr_zero_vector_ack_i(tmr_zero_vector_ack_i),
  .tmr_one_vector_ack_i(tmr_one_vector_ack_i),
  .ext_irq_zero_vector_ack_i(ext_irq_zero_vector_ack_i),
  .ext_irq_one_vector_ack_i(ext_irq_one_vector_ack_i),
  .tmr_zero_overflow_flag_o(tmr_zero_overflow_flag_o),
  .tmr_one_overflow_flag_o(tmr_one_overflow_flag_o),
  .ext_irq_zero_flag_o(ext_irq_zero_flag_o),
  .ext_irq_one_flag_o(ext_irq_one_flag_o)
);

// ===== test/tb_top.sv
/*
  self-checking bench for the timer pair: table of counting cases, then
  prescaler, split mode, external flags, reset values and bad addresses.
  assumes tmr_pkg, the pair and the pin model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  typedef struct packed {
    logic [7:0] timer_mode_select_reg, tl, th, n, gin, m, e0l, e0h, e1l, e1h, ef;
  } row_t;
  logic mclk_i, rst_b_i, wr, rd, p0, p1, xin, pol, tack, eack, eclk;
  logic eclk_on, f0, f1, e0, e1, pls;
  logic [7:0] addr, wdata, rdata, d, d2;
  int bad_count, num_checks, pls_n, v;
  row_t r;
  int pre_want [5] = '{40, 120, 10, 10, 481};
  // mode, preload, pulses, gate input, tl mask, expected bytes, flags
  row_t rows [8] = '{
    '{8'h44,8'h1E,8'hFF,8'h02,8'h00,8'h1F,8'h00,8'h00,8'h00,8'h00,8'hA0},
    '{8'h55,8'hFE,8'h12,8'h03,8'h00,8'hFF,8'h01,8'h13,8'h01,8'h13,8'h00},
    '{8'h55,8'hFF,8'hFF,8'h01,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'hA0},
    '{8'h66,8'hFE,8'h80,8'h03,8'h00,8'hFF,8'h81,8'h80,8'h81,8'h80,8'hA0},
    '{8'h44,8'hE5,8'h01,8'h05,8'h00,8'h1F,8'h0A,8'h01,8'h0A,8'h01,8'h00},
    '{8'hDD,8'h00,8'h00,8'h03,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
    '{8'hDD,8'h00,8'h00,8'h03,8'h01,8'hFF,8'h03,8'h00,8'h03,8'h00,8'h00},
    '{8'h75,8'h10,8'h20,8'h02,8'h00,8'hFF,8'h12,8'h20,8'h10,8'h20,8'h00}
  };

  tmr_pair i_tmr_pair (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .tmr_zero_count_pin_i(p0), .tmr_one_count_pin_i(p1),
    .ext_irq_zero_input_i(xin), .ext_irq_one_input_i(xin),
    .ext_clk_i(eclk), .ext_irq_zero_polarity_i(pol),
    .ext_irq_one_polarity_i(pol), .tmr_zero_vector_ack_i(tack),
    .tmr_one_vector_ack_i(tack), .ext_irq_zero_vector_ack_i(eack),
    .ext_irq_one_vector_ack_i(eack), .tmr_zero_overflow_flag_o(f0),
    .tmr_one_overflow_flag_o(f1), .ext_irq_zero_flag_o(e0),
    .ext_irq_one_flag_o(e1), .tmr_one_overflow_pulse_o(pls)
  );
  pin_model i_pin_model (.mclk_i(mclk_i), .pin0_o(p0), .pin1_o(p1));

  // ----------------------------------------------------------------------
  // clock, external clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    forever begin
      repeat (3) @(posedge mclk_i);
      eclk <= eclk_on ? ~eclk : eclk;
    end
  end
  // sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge mclk_i) if (pls === 1'b1) pls_n++;
  initial begin
    repeat (60000) @(posedge mclk_i);
    bad_count++;
    results();
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
    @(posedge mclk_i);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  // read data lands on the same edge that takes the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dt);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(posedge mclk_i);
    #1 dt = rdata;
  endtask
  task automatic ack(input logic t);
    @(posedge mclk_i);
    if (t) tack <= 1'b1; else eack <= 1'b1;
    @(posedge mclk_i);
    tack <= 1'b0;
    eack <= 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {wr, rd, xin, tack, eack, eclk, eclk_on} = 7'h00;
    {addr, wdata} = 16'h0000;
    pol = 1'b1;
    rst_b_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      xin <= r.gin[0];
      wr_reg(ADDR_TIMER_MODE_SELECT_REG, r.timer_mode_select_reg);
      wr_reg(ADDR_TL0, r.tl);
      wr_reg(ADDR_TL1, r.tl);
      wr_reg(ADDR_TH0, r.th);
      wr_reg(ADDR_TH1, r.th);
      wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h50);
      i_pin_model.pulse(r.n);
      rd_reg(ADDR_TIMER_RUN_FLAG_CONTROL, d);
      chk(d & 8'hA0, r.ef);
      chk({f1, 1'b0, f0, 5'h00}, r.ef);
      wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
      rd_reg(ADDR_TL0, d);
      chk(d & r.m, r.e0l);
      rd_reg(ADDR_TH0, d);
      chk(d, r.e0h);
      rd_reg(ADDR_TL1, d);
      chk(d & r.m, r.e1l);
      rd_reg(ADDR_TH1, d);
      chk(d, r.e1h);
    end
    xin <= 1'b0;
    wr_reg(ADDR_TIMER_MODE_SELECT_REG, 8'h01);
    for (int s = 0; s < 5; s++) begin
      eclk_on = (s == 3);
      wr_reg(ADDR_CLOCK_CONTROL_REG, (s == 4) ? 8'h04 : 8'(s));
      wr_reg(ADDR_TL0, 8'h00);
      wr_reg(ADDR_TH0, 8'h00);
      wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10);
      repeat (480) @(posedge mclk_i);
      wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
      rd_reg(ADDR_TL0, d);
      rd_reg(ADDR_TH0, d2);
      v = {d2, d};
      chk(8'(v >= pre_want[s] - 3 && v <= pre_want[s] + 3), 8'h01);
    end
    eclk_on = 1'b0;
    wr_reg(ADDR_CLOCK_CONTROL_REG, 8'h0C);
    wr_reg(ADDR_TIMER_MODE_SELECT_REG, 8'h13);
    wr_reg(ADDR_TH0, 8'hF0);
    // high byte first, so the tick after the low write overflows
    wr_reg(ADDR_TH1, 8'hFF);
    wr_reg(ADDR_TL1, 8'hFF);
    pls_n = 0;
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10);
    repeat (20) @(posedge mclk_i);
    #1 chk({7'h00, f1}, 8'h00);
    chk(8'(pls_n > 0), 8'h01);
    rd_reg(ADDR_TH0, d);
    chk(d, 8'hF0);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h50);
    repeat (20) @(posedge mclk_i);
    #1 chk({7'h00, f1}, 8'h01);
    ack(1'b1);
    chk({7'h00, f1}, 8'h00);
    wr_reg(ADDR_TIMER_MODE_SELECT_REG, 8'h33);
    rd_reg(ADDR_TL1, d);
    repeat (10) @(posedge mclk_i);
    rd_reg(ADDR_TL1, d2);
    chk(d2, d);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    pol <= 1'b0;
    xin <= 1'b1;
    repeat (5) @(posedge mclk_i);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h05);
    xin <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 chk({6'h00, e1, e0}, 8'h03);
    ack(1'b0);
    chk({6'h00, e1, e0}, 8'h00);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1 chk({6'h00, e1, e0}, 8'h03);
    ack(1'b0);
    chk({6'h00, e1, e0}, 8'h03);
    xin <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    #1 chk({6'h00, e1, e0}, 8'h00);
    // idle ext inputs, else a level flag arms while the syncs read 0
    {xin, pol} <= 2'b01;
    rst_b_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int a = 8'h88; a <= 8'h8E; a++) begin
      rd_reg(8'(a), d);
      chk(d, REG_RESET);
    end
    rd_reg(8'h87, d);
    chk(d, 8'h00);
    wr_reg(8'h90, 8'h5A);
    rd_reg(8'h90, d);
    chk(d, 8'h00);
    wr_reg(ADDR_CLOCK_CONTROL_REG, 8'hFF);
    rd_reg(ADDR_CLOCK_CONTROL_REG, d);
    chk(d, CLOCK_CONTROL_REG_MASK);
    wr_reg(ADDR_TIMER_RUN_FLAG_CONTROL, 8'hA0);
    rd_reg(ADDR_TIMER_RUN_FLAG_CONTROL, d);
    chk(d, 8'hA0);
    results();
  end
endmodule
